// ==== verilog/owd_pkg.sv ====
// Purpose: shared constants, register map and state types of the output watchdog block
// Assumes: 100 MHz core clock, plain register port with 4-bit word address
// Notes: all reset values and timing counts live here
package owd_pkg;
    localparam int unsigned CLK_HZ = 100_000_000;
    localparam int unsigned WD_UNIT_S = 1;                     // interval unit in seconds
    localparam int unsigned WD_TICK_CYCLES = CLK_HZ * WD_UNIT_S; // cycles per watchdog unit
    localparam int unsigned NUM_OUT = 15;
    localparam int unsigned ADDR_W = 4;
    localparam int unsigned DATA_W = 16;

    // register word addresses
    localparam logic [3:0] ADDR_STATION = 4'h0;
    localparam logic [3:0] ADDR_UART = 4'h1;
    localparam logic [3:0] ADDR_DELAYS = 4'h2;
    localparam logic [3:0] ADDR_WD_INTERVAL = 4'h3;
    localparam logic [3:0] ADDR_INIT_VALUE = 4'h4;
    localparam logic [3:0] ADDR_OUTPUTS = 4'h5;
    localparam logic [3:0] ADDR_STATUS = 4'h6;

    // reset values
    localparam logic [7:0] RST_STATION = 8'h01;
    localparam logic [15:0] RST_UART = 16'h0035;   // 9600 baud, no parity, one stop bit
    localparam logic [15:0] RST_DELAYS = 16'h0003;
    localparam logic [15:0] RST_WD_INTERVAL = 16'hffff;
    localparam logic [15:0] RST_INIT_VALUE = 16'h0000;
    localparam logic [15:0] WD_DISABLED = 16'hffff;

    // status register field positions
    localparam int unsigned STAT_EXPIRED_BIT = 0;

    typedef struct packed {
        logic [7:0] station;
        logic [15:0] uart;
        logic [15:0] delays;
        logic [15:0] wd_interval;
        logic [15:0] init_value;
        logic [14:0] outs;
        logic [15:0] wd_count;
        logic expired;
        logic [15:0] rdata;
    } owd_state_t;

    localparam owd_state_t OWD_RESET = '{
        station: RST_STATION,
        uart: RST_UART,
        delays: RST_DELAYS,
        wd_interval: RST_WD_INTERVAL,
        init_value: RST_INIT_VALUE,
        outs: RST_INIT_VALUE[14:0],
        wd_count: 16'h0000,
        expired: 1'b0,
        rdata: 16'h0000
    };

    typedef struct packed {
        logic [31:0] cnt;
        logic tick;
    } owd_div_state_t;

    localparam owd_div_state_t OWD_DIV_RESET = '{cnt: 32'h0000_0000, tick: 1'b0};
endpackage

// ==== verilog/owd_tick_if.sv ====
// Purpose: carries the watchdog unit tick from the divider to the block
// Assumes: single core clock domain
// Notes: tick is a one-cycle pulse
`timescale 1ns/1ps
interface owd_tick_if;
    logic tick;
    modport source (output tick);
    modport sink (input tick);
endinterface

// ==== verilog/owd_tick_div.sv ====
// Purpose: divides the core clock down to one pulse per watchdog unit
// Assumes: TICK_CYCLES of at least 1
// Notes: free running from reset; restarting it on comms is not needed since the
//        counter itself is cleared, at the cost of up to one unit of jitter
`timescale 1ns/1ps
module owd_tick_div #(
    parameter int unsigned TICK_CYCLES = owd_pkg::WD_TICK_CYCLES
) (
    input wire logic core_clk,
    input wire logic rstn,
    owd_tick_if.source tk
);
    localparam logic [31:0] LAST = 32'(TICK_CYCLES - 1);

    owd_pkg::owd_div_state_t st_reg;
    owd_pkg::owd_div_state_t st_next;

    // count up and emit a pulse on wrap
    always_comb begin
        st_next = st_reg;
        st_next.tick = 1'b0;
        if (st_reg.cnt >= LAST) begin
            st_next.cnt = 32'h0000_0000;
            st_next.tick = 1'b1;
        end else begin
            st_next.cnt = st_reg.cnt + 32'h0000_0001;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            st_reg <= owd_pkg::OWD_DIV_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    assign tk.tick = st_reg.tick;
endmodule

// ==== verilog/owd_top.sv ====
// Purpose: fifteen-bit discrete output port with a communications watchdog
// Assumes: the serial framing logic runs on core_clk and flags each good frame
// Notes: settings reset to factory values; no non-volatile storage here
//
// Chosen here: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
module owd_top #(
    parameter int unsigned TICK_CYCLES = owd_pkg::WD_TICK_CYCLES
) (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    input wire logic frame_ok,
    input wire logic [7:0] frame_station,
    output logic [14:0] out_on,
    output logic wd_expired,
    output logic [7:0] station_addr,
    output logic [15:0] uart_setup,
    output logic [15:0] modbus_delays
);
    owd_pkg::owd_state_t st_reg;
    owd_pkg::owd_state_t st_next;
    owd_tick_if tk_if ();
    logic comm_seen;
    logic wd_enabled;
    logic [15:0] count_inc;

    owd_tick_div #(
        .TICK_CYCLES(TICK_CYCLES)
    ) u_div (
        .core_clk(core_clk),
        .rstn(rstn),
        .tk(tk_if.source)
    );

    // only a good frame naming our station counts as host traffic
    assign comm_seen = frame_ok && (frame_station == st_reg.station);
    assign wd_enabled = (st_reg.wd_interval != owd_pkg::WD_DISABLED);
    assign count_inc = st_reg.wd_count + 16'h0001;

    // register writes, then watchdog; expiry wins over a coil write in the same cycle
    always_comb begin
        st_next = st_reg;
        st_next.rdata = 16'h0000;
        if (reg_wr) begin
            if (reg_addr == owd_pkg::ADDR_STATION) begin
                st_next.station = reg_wdata[7:0];
            end else if (reg_addr == owd_pkg::ADDR_UART) begin
                st_next.uart = reg_wdata;
            end else if (reg_addr == owd_pkg::ADDR_DELAYS) begin
                st_next.delays = reg_wdata;
            end else if (reg_addr == owd_pkg::ADDR_WD_INTERVAL) begin
                st_next.wd_interval = reg_wdata;
            end else if (reg_addr == owd_pkg::ADDR_INIT_VALUE) begin
                st_next.init_value = reg_wdata;
            end else if (reg_addr == owd_pkg::ADDR_OUTPUTS) begin
                st_next.outs = reg_wdata[14:0];
            end
        end
        if (reg_rd) begin
            if (reg_addr == owd_pkg::ADDR_STATION) begin
                st_next.rdata = {8'h00, st_reg.station};
            end else if (reg_addr == owd_pkg::ADDR_UART) begin
                st_next.rdata = st_reg.uart;
            end else if (reg_addr == owd_pkg::ADDR_DELAYS) begin
                st_next.rdata = st_reg.delays;
            end else if (reg_addr == owd_pkg::ADDR_WD_INTERVAL) begin
                st_next.rdata = st_reg.wd_interval;
            end else if (reg_addr == owd_pkg::ADDR_INIT_VALUE) begin
                st_next.rdata = st_reg.init_value;
            end else if (reg_addr == owd_pkg::ADDR_OUTPUTS) begin
                st_next.rdata = {1'b0, st_reg.outs};
            end else if (reg_addr == owd_pkg::ADDR_STATUS) begin
                st_next.rdata = 16'h0000;
                st_next.rdata[owd_pkg::STAT_EXPIRED_BIT] = st_reg.expired;
            end else begin
                st_next.rdata = 16'h0000; // unmapped reads as zero
            end
        end
        // host traffic restarts the interval and re-arms the watchdog
        if (comm_seen) begin
            st_next.wd_count = 16'h0000;
            st_next.expired = 1'b0;
        end else if (tk_if.tick && wd_enabled && !st_reg.expired) begin
            st_next.wd_count = count_inc;
            if (count_inc >= st_reg.wd_interval) begin
                // fires once per silence; the host may set coils again afterwards
                st_next.outs = st_next.init_value[14:0];
                st_next.expired = 1'b1;
            end
        end
    end

    // reset loads factory settings and the power-on pattern
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            st_reg <= owd_pkg::OWD_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    assign reg_rdata = st_reg.rdata;
    assign out_on = st_reg.outs;
    assign wd_expired = st_reg.expired;
    assign station_addr = st_reg.station;
    assign uart_setup = st_reg.uart;
    assign modbus_delays = st_reg.delays;
endmodule

// ==== tb/owd_props.sv ====
// Purpose: port-level checks for owd_top
// Assumes: one clock, rstn async active low
// Notes: init value is internal, so the forced pattern is judged by the bench
`timescale 1ns/1ps
module owd_props #(parameter int unsigned TICK_CYCLES = 10) (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_rdata,
    input wire logic frame_ok,
    input wire logic [7:0] frame_station,
    input wire logic [14:0] out_on,
    input wire logic wd_expired,
    input wire logic [7:0] station_addr,
    input wire logic [15:0] uart_setup,
    input wire logic [15:0] modbus_delays
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rstn);
    // a frame counts only when it carries our own station
    wire logic hit = frame_ok && frame_station == station_addr;
    chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
        else $error("read data not idle");
    chk_hit_clears: assert property (hit |=> !wd_expired)
        else $error("good frame did not clear expiry");
    chk_exp_holds: assert property (wd_expired && !hit |=> wd_expired)
        else $error("expiry dropped without a good frame");
    chk_out_cause: assert property
        ($changed(out_on) |-> $past(reg_wr && reg_addr == 4'h5) || $rose(wd_expired))
        else $error("outputs moved without cause");
    chk_out_write: assert property
        (reg_wr && reg_addr == 4'h5 |=> out_on == $past(reg_wdata[14:0]) || $rose(wd_expired))
        else $error("output write lost");
    chk_outs_read: assert property (reg_rd && reg_addr == 4'h5 |=> reg_rdata == {1'b0, $past(out_on)})
        else $error("output readback wrong");
    chk_status_read: assert property (reg_rd && reg_addr == 4'h6 |=> reg_rdata == {15'h0000, $past(wd_expired)})
        else $error("status readback wrong");
    // a good frame in the firing cycle restarts the interval instead
    chk_fire_quiet: assert property ($rose(wd_expired) |-> $past(!hit))
        else $error("expiry despite a good frame");
    chk_station_wr: assert property (reg_wr && reg_addr == 4'h0 |=> station_addr == $past(reg_wdata[7:0]))
        else $error("station write lost");
    chk_uart_wr: assert property (reg_wr && reg_addr == 4'h1 |=> uart_setup == $past(reg_wdata))
        else $error("uart write lost");
    chk_delay_wr: assert property (reg_wr && reg_addr == 4'h2 |=> modbus_delays == $past(reg_wdata))
        else $error("delay write lost");
endmodule
bind owd_top owd_props #(.TICK_CYCLES(TICK_CYCLES)) owd_props_i (.core_clk(core_clk), .rstn(rstn),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .frame_ok(frame_ok), .frame_station(frame_station), .out_on(out_on), .wd_expired(wd_expired),
    .station_addr(station_addr), .uart_setup(uart_setup), .modbus_delays(modbus_delays));

// ==== tb/owd_host_model.sv ====
// Purpose: host stand-in that hands received frames to the block
// Assumes: framing already done, one pulse per frame
// Notes: station lines toggle between frames so stale values never match by luck
`timescale 1ns/1ps
module owd_host_model (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic send,
    input wire logic [7:0] sta,
    output logic frame_ok,
    output logic [7:0] frame_station
);
    // one good frame per send cycle, addressed to sta
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            frame_ok <= 1'b0;
            frame_station <= 8'h00;
        end else begin
            frame_ok <= send;
            frame_station <= send ? sta : ~frame_station;
        end
    end
endmodule

// ==== tb/test_owd_top.sv ====
// Purpose: self-checking bench for owd_top
// Assumes: tick shortened to 10 cycles, so one interval unit is 10 cycles
// Notes: frames come from the host model one cycle after send
`timescale 1ns/1ps
module test_owd_top;
    logic core_clk = 0, rstn = 0, reg_wr = 0, reg_rd = 0, send = 0, frame_ok, wd_expired;
    logic [3:0] reg_addr = 0;
    logic [15:0] reg_wdata = 0, reg_rdata, uart_setup, modbus_delays;
    logic [7:0] sta = 0, frame_station, station_addr;
    logic [14:0] out_on;
    int error_cnt = 0, n_compared = 0, cyc = 0, k;
    logic [15:0] v[3] = '{16'h0022, 16'h0066, 16'h1005};
    owd_top #(.TICK_CYCLES(10)) owd_top_i (.core_clk(core_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .frame_ok(frame_ok), .frame_station(frame_station),
        .out_on(out_on), .wd_expired(wd_expired), .station_addr(station_addr), .uart_setup(uart_setup),
        .modbus_delays(modbus_delays));
    owd_host_model owd_host_model_i (.core_clk(core_clk), .rstn(rstn), .send(send), .sta(sta), .frame_ok(frame_ok),
        .frame_station(frame_station));
    always #5 core_clk = ~core_clk;
    // hang guard: the sequence needs well under 2000 cycles
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 2000) begin
            error_cnt++;
            results();
        end
    end
    task automatic cmp(input logic [15:0] g, input logic [15:0] e);
        n_compared++;
        if (g !== e) begin
            error_cnt++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge core_clk);
        reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask
    // data stand only in the cycle after the read edge
    task automatic rd(input logic [3:0] a, input logic [15:0] e);
        @(posedge core_clk);
        reg_addr <= a; reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 cmp(reg_rdata, e);
    endtask
    task automatic frm(input logic [7:0] s);
        @(posedge core_clk);
        send <= 1'b1; sta <= s;
        @(posedge core_clk);
        send <= 1'b0;
    endtask
    task automatic results();
        $display("compared %0d, mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge core_clk);
        rstn <= 1'b1;
        #1 cmp({8'h00, station_addr}, 16'h0001);
        cmp(uart_setup, 16'h0035);
        cmp(modbus_delays, 16'h0003);
        cmp({1'b0, out_on}, 16'h0000);
        rd(4'h3, 16'hffff);
        rd(4'h4, 16'h0000);
        repeat (50) @(posedge core_clk);
        #1 cmp({15'h0, wd_expired}, 16'h0000);
        for (k = 0; k < 3; k++) begin
            wr(k[3:0], v[k]);
            rd(k[3:0], v[k]);
        end
        wr(4'h5, 16'hd555);
        rd(4'h5, 16'h5555);
        cmp({1'b0, out_on}, 16'h5555);
        wr(4'h6, 16'hffff);
        rd(4'h6, 16'h0000);
        rd(4'h7, 16'h0000);
        wr(4'h4, 16'hab5a);
        wr(4'h3, 16'h0003);
        frm(8'h22);
        repeat (15) @(posedge core_clk);
        frm(8'h23);
        #1 cmp({15'h0, wd_expired}, 16'h0000);
        // three ticks land within 30 cycles of the 0x22 reload; a wrongly honoured
        // frame to 0x23 would push expiry past the edge checked here
        repeat (14) @(posedge core_clk);
        #1 cmp({15'h0, wd_expired}, 16'h0001);
        cmp({1'b0, out_on}, 16'h2b5a);
        rd(4'h6, 16'h0001);
        frm(8'h22);
        repeat (2) @(posedge core_clk);
        #1 cmp({15'h0, wd_expired}, 16'h0000);
        cmp({1'b0, out_on}, 16'h2b5a);
        repeat (6) begin
            repeat (12) @(posedge core_clk);
            frm(8'h22);
        end
        #1 cmp({15'h0, wd_expired}, 16'h0000);
        results();
    end
endmodule
